// [verilog/bdc_cfg.svh]
// offsets, field values, reset values and timing constants of the dosing controller
//
// Summary of operation
// - enabled: drive pin push-pull, control pin input
// - pin configuration writes refused while enabled
// - disabling clears both pins, frees configuration
// - softkey acts after 2 s hold, then release
// - stopped: 0.5-4 s high pulse starts
// - running: 0.5-4 s high pulse stops
// - stopped: pulse over 5 s resets quantity
// - start drives output high, counts down on flow
// - stop freezes counter, start resumes from it
// - reset only when stopped or finished, reloads preset
// - preset in tenths, at most 9999.9
// - unit selects one of seven volume units
// - correction +-999.99, counter halts at negated correction
// - preset plus correction not positive: warn, fix
// - running with no flow for timeout: flag
// - timeout settable from 0.5 s to 10 s
`ifndef BDC_CFG_SVH
`define BDC_CFG_SVH

// clock and slow tick
`define BDC_CLK_MHZ        100
`define BDC_TICK_US        1000

// apb byte addresses
`define BDC_ADDR_CTRL      8'h00
`define BDC_ADDR_PINCFG    8'h04
`define BDC_ADDR_PRESET    8'h08
`define BDC_ADDR_UNIT      8'h0c
`define BDC_ADDR_CORR      8'h10
`define BDC_ADDR_TMO       8'h14
`define BDC_ADDR_COUNT     8'h18
`define BDC_ADDR_STATUS    8'h1c
`define BDC_ADDR_IRQSTAT   8'h20
`define BDC_ADDR_IRQMASK   8'h24

// event bits of the interrupt status
`define BDC_EV_DONE        0
`define BDC_EV_TMO         1
`define BDC_EV_WARN        2

// value limits and reset values
`define BDC_PRESET_MAX     32'h0001869f
`define BDC_CORR_MAX       32'sh0001869f
`define BDC_CORR_MIN       -32'sh0001869f
`define BDC_UNIT_MAX       32'h00000006
`define BDC_UNIT_RST       3'h1
`define BDC_TMO_MIN        32'h00000005
`define BDC_TMO_MAX        32'h00000064
`define BDC_TMO_RST        7'h05

// timing in milliseconds
`define BDC_PULSE_MIN_MS   13'h01f4
`define BDC_PULSE_MAX_MS   13'h0fa0
`define BDC_PULSE_RST_MS   13'h1388
`define BDC_KEY_HOLD_MS    12'h7d0
`define BDC_TMO_STEP_MS    14'h0064

`endif

// [verilog/bdc_pkg.sv]
// types of the dosing controller
package bdc_pkg;

   typedef enum logic [2:0] {
      BDC_STOP = 3'b001,
      BDC_RUN  = 3'b010,
      BDC_DONE = 3'b100
   } bdc_state_e;

   typedef struct packed {
      logic out;
      logic oe;
   } bdc_pin_s;

   typedef struct packed {
      logic [2:0]        ctrlSync;
      logic              ctrlLvl;
      logic [2:0]        flowSync;
      logic              flowLvl;
      logic [2:0][2:0]   keySync;
      logic [2:0]        keyLvl;
      logic [31:0]       divCnt;
      logic              msTick;
      logic [12:0]       ctrlMs;
      logic [11:0]       keyMs;
      logic [2:0]        keySeen;
      bdc_state_e        state;
      logic signed [21:0] count;
      logic [16:0]       preset;
      logic signed [21:0] corr;
      logic [2:0]        unit;
      logic [6:0]        tmo;
      logic [13:0]       flowMs;
      logic              tmoHit;
      logic              enable;
      logic [3:0]        pinCfg;
      logic [2:0]        irqStat;
      logic [2:0]        irqMask;
      logic              irq;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      bdc_pin_s          ctrlPin;
      bdc_pin_s          drvPin;
   } bdc_regs_s;

endpackage : bdc_pkg

// [verilog/bdc_dosing_ctrl.sv]
// batch dosing controller with apb register access
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "bdc_cfg.svh"

module bdc_dosing_ctrl #(
   parameter int TICK_CYCLES = `BDC_TICK_US * `BDC_CLK_MHZ
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // apb slave
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // pins
   input  wire logic              ctrlPinIn,
   output      bdc_pkg::bdc_pin_s ctrlPin,
   output      bdc_pkg::bdc_pin_s drivePin,
   input  wire logic              flowPulseIn,
   input  wire logic [2:0]        softkeyIn,
   // interrupt
   output      logic              irq
);

   if (TICK_CYCLES < 2) begin : gTickChk
      $error("TICK_CYCLES must be at least 2");
   end

   // =====================================================================
   // helpers
   function automatic logic signed [21:0] toCnt(input logic [16:0] p);
      toCnt = $signed(22'({5'h00, p} * 22'd10));
   endfunction : toCnt

   function automatic logic corrBad(input logic [16:0] p, input logic signed [21:0] c);
      corrBad = (toCnt(p) + c) <= 22'sd0;
   endfunction : corrBad

   function automatic logic signed [21:0] corrFix(input logic [16:0] p);
      corrFix = -(toCnt(p) - 22'sd10);
   endfunction : corrFix

   // =====================================================================
   // state
   bdc_pkg::bdc_regs_s s;
   bdc_pkg::bdc_regs_s next_s;

   logic               acc;
   logic [2:0]         ev;
   logic               doStart;
   logic               doStop;
   logic               doReset;
   logic signed [21:0] halt;
   logic signed [21:0] nextCnt;
   logic [13:0]        tmoLim;
   logic [31:0]        rdata;
   logic               err;

   always_comb begin
      next_s  = s;
      acc     = psel & penable & s.pready;
      ev      = 3'h0;
      doStart = 1'b0;
      doStop  = 1'b0;
      doReset = 1'b0;
      halt    = -s.corr;
      nextCnt = s.count;
      tmoLim  = 14'({7'h00, s.tmo} * `BDC_TMO_STEP_MS);
      rdata   = 32'h0;
      err     = 1'b0;

      // input synchronisers, level taken when stages two and three agree
      next_s.ctrlSync = {s.ctrlSync[1:0], ctrlPinIn};
      if (s.ctrlSync[1] == s.ctrlSync[2]) begin
         next_s.ctrlLvl = s.ctrlSync[2];
      end
      next_s.flowSync = {s.flowSync[1:0], flowPulseIn};
      if (s.flowSync[1] == s.flowSync[2]) begin
         next_s.flowLvl = s.flowSync[2];
      end
      for (int k = 0; k < 3; k++) begin
         next_s.keySync[k] = {s.keySync[k][1:0], softkeyIn[k]};
         if (s.keySync[k][1] == s.keySync[k][2]) begin
            next_s.keyLvl[k] = s.keySync[k][2];
         end
      end

      // millisecond tick
      next_s.msTick = 1'b0;
      if (s.divCnt == 32'(TICK_CYCLES - 1)) begin
         next_s.divCnt = 32'h0;
         next_s.msTick = 1'b1;
      end else begin
         next_s.divCnt = s.divCnt + 32'h1;
      end

      // control input pulse width, judged at the falling edge
      if (s.ctrlLvl && s.msTick && s.ctrlMs != 13'h1fff) begin
         next_s.ctrlMs = s.ctrlMs + 13'h1;
      end
      if (s.ctrlLvl && !next_s.ctrlLvl) begin
         next_s.ctrlMs = 13'h0;
         if (s.enable && s.ctrlMs > `BDC_PULSE_MIN_MS && s.ctrlMs < `BDC_PULSE_MAX_MS) begin
            doStart = (s.state == bdc_pkg::BDC_STOP);
            doStop  = (s.state == bdc_pkg::BDC_RUN);
         end else if (s.enable && s.ctrlMs > `BDC_PULSE_RST_MS) begin
            // long pulse resets, finished counts as stopped
            doReset = (s.state != bdc_pkg::BDC_RUN);
         end
      end

      // softkeys act on release after a long hold
      if (|s.keyLvl) begin
         next_s.keySeen = s.keySeen | s.keyLvl;
         if (s.msTick && s.keyMs != 12'hfff) begin
            next_s.keyMs = s.keyMs + 12'h1;
         end
      end else if (|s.keySeen) begin
         next_s.keySeen = 3'h0;
         next_s.keyMs   = 12'h0;
         if (s.enable && s.keyMs >= `BDC_KEY_HOLD_MS) begin
            doStart = doStart | s.keySeen[0];
            doStop  = doStop | s.keySeen[1];
            doReset = doReset | s.keySeen[2];
         end
      end

      // dosing sequence
      case (s.state)
         bdc_pkg::BDC_STOP: begin
            if (doReset) begin
               next_s.count = toCnt(s.preset);
            end else if (doStart && s.count > halt) begin
               next_s.state  = bdc_pkg::BDC_RUN;
               next_s.flowMs = 14'h0;
               next_s.tmoHit = 1'b0;
            end
         end
         bdc_pkg::BDC_RUN: begin
            if (doStop) begin
               next_s.state = bdc_pkg::BDC_STOP;
            end else begin
               if (s.flowLvl && !next_s.flowLvl) begin
                  nextCnt       = s.count - 22'sd1;
                  next_s.count  = nextCnt;
                  next_s.flowMs = 14'h0;
                  if (nextCnt <= halt) begin
                     next_s.state      = bdc_pkg::BDC_DONE;
                     ev[`BDC_EV_DONE] = 1'b1;
                  end
               end else if (s.msTick && s.flowMs != 14'h3fff) begin
                  next_s.flowMs = s.flowMs + 14'h1;
               end
            end
            // no flow for timeout, also when a stop lands then
            if (!s.tmoHit && s.flowMs >= tmoLim) begin
               next_s.tmoHit    = 1'b1;
               ev[`BDC_EV_TMO] = 1'b1;
            end
         end
         bdc_pkg::BDC_DONE: begin
            if (doReset) begin
               next_s.count = toCnt(s.preset);
               next_s.state = bdc_pkg::BDC_STOP;
            end
         end
         default: begin
            next_s.state = bdc_pkg::BDC_STOP;
         end
      endcase

      // register decode, checked in the first access cycle
      case (paddr)
         `BDC_ADDR_CTRL: begin
            rdata = {31'h0, s.enable};
         end
         `BDC_ADDR_PINCFG: begin
            rdata = {28'h0, s.pinCfg};
            err   = pwrite & s.enable;
         end
         `BDC_ADDR_PRESET: begin
            rdata = {15'h0, s.preset};
            err   = pwrite && (pwdata > `BDC_PRESET_MAX);
         end
         `BDC_ADDR_UNIT: begin
            rdata = {29'h0, s.unit};
            err   = pwrite && (pwdata > `BDC_UNIT_MAX);
         end
         `BDC_ADDR_CORR: begin
            rdata = {{10{s.corr[21]}}, s.corr};
            err   = pwrite && ($signed(pwdata) > `BDC_CORR_MAX
                               || $signed(pwdata) < `BDC_CORR_MIN);
         end
         `BDC_ADDR_TMO: begin
            rdata = {25'h0, s.tmo};
            err   = pwrite && (pwdata < `BDC_TMO_MIN || pwdata > `BDC_TMO_MAX);
         end
         `BDC_ADDR_COUNT: begin
            rdata = {{10{s.count[21]}}, s.count};
            err   = pwrite;
         end
         `BDC_ADDR_STATUS: begin
            rdata = {28'h0, s.tmoHit, s.state};
            err   = pwrite;
         end
         `BDC_ADDR_IRQSTAT: begin
            rdata = {29'h0, s.irqStat};
            err   = pwrite;
         end
         `BDC_ADDR_IRQMASK: begin
            rdata = {29'h0, s.irqMask};
         end
         default: begin
            err = 1'b1;
         end
      endcase

      next_s.pready  = psel & penable & ~s.pready;
      next_s.pslverr = next_s.pready & err;
      if (next_s.pready) begin
         next_s.prdata = err ? 32'h0 : rdata;
      end

      // writes take effect at the edge that completes the access
      if (acc && pwrite && !s.pslverr) begin
         case (paddr)
            `BDC_ADDR_CTRL: begin
               next_s.enable = pwdata[0];
               if (!pwdata[0]) begin
                  next_s.pinCfg = 4'h0;
                  next_s.state  = bdc_pkg::BDC_STOP;
               end else if (!s.enable) begin
                  next_s.state = bdc_pkg::BDC_STOP;
                  next_s.count = toCnt(s.preset);
               end
            end
            `BDC_ADDR_PINCFG: begin
               next_s.pinCfg = pwdata[3:0];
            end
            `BDC_ADDR_PRESET: begin
               next_s.preset = pwdata[16:0];
               if (corrBad(pwdata[16:0], s.corr)) begin
                  next_s.corr       = corrFix(pwdata[16:0]);
                  ev[`BDC_EV_WARN] = 1'b1;
               end
            end
            `BDC_ADDR_UNIT: begin
               next_s.unit = pwdata[2:0];
            end
            `BDC_ADDR_CORR: begin
               next_s.corr = pwdata[21:0];
               if (corrBad(s.preset, $signed(pwdata[21:0]))) begin
                  next_s.corr       = corrFix(s.preset);
                  ev[`BDC_EV_WARN] = 1'b1;
               end
            end
            `BDC_ADDR_TMO: begin
               next_s.tmo = pwdata[6:0];
            end
            `BDC_ADDR_IRQMASK: begin
               next_s.irqMask = pwdata[2:0];
            end
            default: begin
               next_s.irqMask = s.irqMask;
            end
         endcase
      end

      // sticky events: a read clears only the bits it returned, later events survive
      if (acc && !pwrite && paddr == `BDC_ADDR_IRQSTAT) begin
         next_s.irqStat = s.irqStat & ~s.prdata[2:0];
      end
      next_s.irqStat = next_s.irqStat | ev;
      next_s.irq     = |(next_s.irqStat & next_s.irqMask);

      if (next_s.enable) begin
         // control pin becomes input, drive pin push-pull
         next_s.ctrlPin.oe  = 1'b0;
         next_s.ctrlPin.out = 1'b0;
         next_s.drvPin.oe   = 1'b1;
         next_s.drvPin.out  = (next_s.state == bdc_pkg::BDC_RUN);
      end else begin
         next_s.ctrlPin.oe  = next_s.pinCfg[0];
         next_s.ctrlPin.out = next_s.pinCfg[1];
         next_s.drvPin.oe   = next_s.pinCfg[2];
         next_s.drvPin.out  = next_s.pinCfg[3];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s         <= '0;
         s.state   <= bdc_pkg::BDC_STOP;
         s.unit    <= `BDC_UNIT_RST;
         s.tmo     <= `BDC_TMO_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata   = s.prdata;
   assign pready   = s.pready;
   assign pslverr  = s.pslverr;
   assign ctrlPin  = s.ctrlPin;
   assign drivePin = s.drvPin;
   assign irq      = s.irq;

   // =====================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   pin_lock_a : assert property (
      (acc && pwrite && paddr == `BDC_ADDR_PINCFG && s.enable)
         |-> s.pslverr ##1 (s.pinCfg == $past(s.pinCfg)))
      else $error("pin configuration changed while dosing enabled");

   disable_off_a : assert property (
      $fell(s.enable) |-> (s.pinCfg == 4'h0 && !s.drvPin.oe && !s.ctrlPin.oe))
      else $error("pins not deactivated on disable");

   ctrl_input_a : assert property (
      s.enable |-> (!s.ctrlPin.oe && s.drvPin.oe))
      else $error("pin roles wrong while enabled");

   drive_run_a : assert property (
      (s.enable && $past(s.enable)) |-> (s.drvPin.out == (s.state == bdc_pkg::BDC_RUN)))
      else $error("drive pin does not follow running state");

   count_freeze_a : assert property (
      (s.state == bdc_pkg::BDC_STOP && !acc)
         |=> (s.count == $past(s.count) || s.count == toCnt(s.preset)))
      else $error("counter moved while stopped");

   halt_point_a : assert property (
      (s.state == bdc_pkg::BDC_RUN ##1 s.state == bdc_pkg::BDC_DONE)
         |-> (s.count <= -s.corr && !s.drvPin.out && s.irqStat[`BDC_EV_DONE]))
      else $error("finish without reaching halt point");

   corr_fix_a : assert property (
      (acc && pwrite && !s.pslverr
         && (paddr == `BDC_ADDR_PRESET || paddr == `BDC_ADDR_CORR))
         |=> (toCnt(s.preset) + s.corr > 22'sd0))
      else $error("corrected target not positive");

   flow_timeout_a : assert property (
      (s.state == bdc_pkg::BDC_RUN && !s.tmoHit && s.flowMs >= tmoLim && !acc)
         |=> (s.tmoHit && s.irqStat[`BDC_EV_TMO]))
      else $error("flow timeout not raised");

   value_range_a : assert property (
      (s.tmo >= 7'h05 && s.tmo <= 7'h64 && s.unit <= 3'h6 && s.preset <= 17'h1869f))
      else $error("setting out of range");

endmodule : bdc_dosing_ctrl

// [sim/bdc_ctrl_partner.sv]
// operator and flow source model driving the control and flow inputs
`timescale 1ns/1ps

module bdc_ctrl_partner #(
   parameter int TICK = 2
) (
   // clock
   input  wire logic sys_clk,
   // lines into the controller
   output      logic ctrlLine,
   output      logic flowPulse
);
   // ==========================================
   // line drive
   // never left floating
   initial begin
      ctrlLine  = 1'b0;
      flowPulse = 1'b0;
   end

   // high pulse of ms milliseconds, then a settle gap
   task automatic pulse(input int ms);
      @(posedge sys_clk);
      ctrlLine <= 1'b1;
      repeat (ms * TICK) @(posedge sys_clk);
      ctrlLine <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask : pulse

   // n flow pulses, gap sets a prompt or slow pace
   task automatic flow(input int n, input int gap);
      repeat (n) begin
         @(posedge sys_clk);
         flowPulse <= 1'b1;
         repeat (4) @(posedge sys_clk);
         flowPulse <= 1'b0;
         repeat (gap) @(posedge sys_clk);
      end
   endtask : flow
endmodule : bdc_ctrl_partner

// [sim/testbench.sv]
// self-checking bench of the dosing controller
`timescale 1ns/1ps
`include "bdc_cfg.svh"

module testbench;
   localparam int          TICK = 2;
   localparam logic [31:0] ALL  = 32'hffffffff;
   // ==========================================
   // signals
   logic              sys_clk   = 1'b0;
   logic              resetn;
   logic [7:0]        paddr;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [31:0]       pwdata;
   logic [2:0]        softkeyIn;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              ctrlLine;
   logic              flowPulse;
   logic              irq;
   bdc_pkg::bdc_pin_s ctrlPin;
   bdc_pkg::bdc_pin_s drivePin;
   int                err_total = 0;
   int                checks    = 0;

   always #5 sys_clk = ~sys_clk;

   bdc_dosing_ctrl #(.TICK_CYCLES(TICK)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ctrlPinIn(ctrlLine), .ctrlPin(ctrlPin),
      .drivePin(drivePin), .flowPulseIn(flowPulse), .softkeyIn(softkeyIn), .irq(irq));

   bdc_ctrl_partner #(.TICK(TICK)) u_partner (
      .sys_clk(sys_clk), .ctrlLine(ctrlLine), .flowPulse(flowPulse));

   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      // pready stands for one cycle only
      check("pready pulse", {31'h0, pready}, 32'h0);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // only the watchdog ends a hung access
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input string what, input logic [7:0] a, input logic [31:0] d,
                     input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      check(what, {31'h0, e}, {31'h0, experr});
   endtask : wr

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] mask,
                     input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r & mask, exp);
      check(what, {31'h0, e}, {31'h0, a > `BDC_ADDR_IRQMASK});
   endtask : rd

   task automatic pins(input logic [1:0] c, input logic [1:0] d);
      repeat (2) @(posedge sys_clk);
      check("ctrlPin", {30'h0, ctrlPin}, {30'h0, c});
      check("drivePin", {30'h0, drivePin}, {30'h0, d});
   endtask : pins

   task automatic key(input int idx, input int ms);
      @(posedge sys_clk);
      softkeyIn[idx] <= 1'b1;
      repeat (ms * TICK) @(posedge sys_clk);
      softkeyIn[idx] <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask : key

   // ==========================================
   // scenarios
   task automatic reset_values();
      rd("ctrl", `BDC_ADDR_CTRL, ALL, 32'h0);
      rd("unit", `BDC_ADDR_UNIT, ALL, 32'h1);
      rd("tmo", `BDC_ADDR_TMO, ALL, 32'h5);
      rd("status", `BDC_ADDR_STATUS, ALL, 32'h1);
      rd("unmapped", 8'h28, ALL, 32'h0);
      wr("count ro", `BDC_ADDR_COUNT, 32'h5, 1'b1);
   endtask : reset_values

   task automatic limits();
      wr("preset max", `BDC_ADDR_PRESET, 32'h0001869f, 1'b0);
      wr("preset over", `BDC_ADDR_PRESET, 32'h000186a0, 1'b1);
      rd("preset", `BDC_ADDR_PRESET, ALL, 32'h0001869f);
      for (int u = 0; u < 8; u++) begin
         wr("unit", `BDC_ADDR_UNIT, u, u == 7);
      end
      rd("unit", `BDC_ADDR_UNIT, ALL, 32'h6);
      wr("tmo low", `BDC_ADDR_TMO, 32'h4, 1'b1);
      wr("tmo high", `BDC_ADDR_TMO, 32'h65, 1'b1);
      wr("tmo max", `BDC_ADDR_TMO, 32'h64, 1'b0);
      wr("tmo min", `BDC_ADDR_TMO, 32'h5, 1'b0);
      wr("corr max", `BDC_ADDR_CORR, 32'h0001869f, 1'b0);
      wr("corr over", `BDC_ADDR_CORR, 32'h000186a0, 1'b1);
      wr("corr under", `BDC_ADDR_CORR, 32'hfffe7960, 1'b1);
      wr("corr min", `BDC_ADDR_CORR, 32'hfffe7961, 1'b0);
      rd("corr", `BDC_ADDR_CORR, ALL, 32'hfffe7961);
      wr("corr", `BDC_ADDR_CORR, 32'h0, 1'b0);
   endtask : limits

   task automatic correction();
      wr("preset", `BDC_ADDR_PRESET, 32'h0000000a, 1'b0);
      wr("mask", `BDC_ADDR_IRQMASK, 32'h0, 1'b0);
      wr("corr", `BDC_ADDR_CORR, 32'hffffff38, 1'b0);
      rd("corr fixed", `BDC_ADDR_CORR, ALL, 32'hffffffa6);
      repeat (2) @(posedge sys_clk);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr("mask", `BDC_ADDR_IRQMASK, 32'h7, 1'b0);
      repeat (2) @(posedge sys_clk);
      check("irq warn", {31'h0, irq}, 32'h1);
      rd("irq status", `BDC_ADDR_IRQSTAT, ALL, 32'h4);
      repeat (2) @(posedge sys_clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr("corr", `BDC_ADDR_CORR, 32'hffffffce, 1'b0);
      rd("corr", `BDC_ADDR_CORR, ALL, 32'hffffffce);
   endtask : correction

   task automatic pin_ownership();
      wr("pincfg", `BDC_ADDR_PINCFG, 32'hf, 1'b0);
      pins(2'h3, 2'h3);
      wr("enable", `BDC_ADDR_CTRL, 32'h1, 1'b0);
      pins(2'h0, 2'h1);
      wr("pincfg locked", `BDC_ADDR_PINCFG, 32'h0, 1'b1);
      rd("count", `BDC_ADDR_COUNT, ALL, 32'h64);
   endtask : pin_ownership

   task automatic control_line();
      u_partner.pulse(200);
      rd("short pulse", `BDC_ADDR_STATUS, 32'h7, 32'h1);
      u_partner.pulse(1000);
      rd("started", `BDC_ADDR_STATUS, 32'h7, 32'h2);
      pins(2'h0, 2'h3);
      u_partner.flow(20, 4);
      rd("count run", `BDC_ADDR_COUNT, ALL, 32'h50);
      u_partner.pulse(1000);
      rd("stopped", `BDC_ADDR_STATUS, 32'h7, 32'h1);
      pins(2'h0, 2'h1);
      u_partner.flow(5, 30);
      rd("count frozen", `BDC_ADDR_COUNT, ALL, 32'h50);
      u_partner.pulse(1000);
      u_partner.pulse(6000);
      rd("reset in run", `BDC_ADDR_STATUS, 32'hf, 32'ha);
      rd("count kept", `BDC_ADDR_COUNT, ALL, 32'h50);
      u_partner.flow(40, 4);
      rd("count halt", `BDC_ADDR_COUNT, ALL, 32'h32);
      rd("done", `BDC_ADDR_STATUS, 32'h7, 32'h4);
      pins(2'h0, 2'h1);
      check("irq done", {31'h0, irq}, 32'h1);
      rd("irq status", `BDC_ADDR_IRQSTAT, ALL, 32'h3);
      u_partner.pulse(1000);
      rd("start in done", `BDC_ADDR_STATUS, 32'h7, 32'h4);
      u_partner.pulse(6000);
      rd("reset", `BDC_ADDR_STATUS, 32'h7, 32'h1);
      rd("count reload", `BDC_ADDR_COUNT, ALL, 32'h64);
   endtask : control_line

   task automatic softkeys();
      key(0, 2500);
      rd("key start", `BDC_ADDR_STATUS, 32'h7, 32'h2);
      u_partner.flow(10, 4);
      key(1, 1000);
      rd("key short", `BDC_ADDR_STATUS, 32'h7, 32'h2);
      key(1, 2500);
      rd("key stop", `BDC_ADDR_STATUS, 32'h7, 32'h1);
      rd("count", `BDC_ADDR_COUNT, ALL, 32'h5a);
      key(2, 2500);
      rd("key reset", `BDC_ADDR_COUNT, ALL, 32'h64);
      wr("disable", `BDC_ADDR_CTRL, 32'h0, 1'b0);
      pins(2'h0, 2'h0);
      rd("pincfg", `BDC_ADDR_PINCFG, ALL, 32'h0);
      wr("pincfg free", `BDC_ADDR_PINCFG, 32'h5, 1'b0);
      pins(2'h1, 2'h1);
   endtask : softkeys

   // ==========================================
   // run control
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      resetn    = 1'b0;
      paddr     = 8'h00;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      pwdata    = 32'h0;
      softkeyIn = 3'h0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset_values();
      limits();
      correction();
      pin_ownership();
      control_line();
      softkeys();
      finish_test();
   end

   initial begin
      // about 80000 cycles, well above the ~51000 the scenarios need
      #800000;
      err_total++;
      finish_test();
   end
endmodule : testbench
